// ===== logic/csw_pkg.sv
package csw_pkg;

    // ------------------------------------------------------------
    // register offsets in the external address space
    // ------------------------------------------------------------
    localparam logic [15:0] OFS_PORT_DATA = 16'h0003;
    localparam logic [15:0] OFS_PORT_DIR = 16'h0004;
    localparam logic [15:0] OFS_CS_ENABLE = 16'h0005;
    localparam logic [15:0] OFS_WAKEUP = 16'h0006;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PORT_DATA = 8'h00;
    localparam logic [7:0] RST_PORT_DIR = 8'hff;
    localparam logic [7:0] RST_CS_ENABLE = 8'hff;
    localparam logic [7:0] RST_WAKEUP = 8'h60;
    localparam logic [7:0] CS_ALL_OFF = 8'hff;
    localparam logic [7:0] RDATA_NONE = 8'h00;

    // idle level of a disabled wakeup input, matches the reset readback
    localparam logic WAKE_HELD_LEVEL = 1'b1;

    // ------------------------------------------------------------
    // wakeup control field positions
    // ------------------------------------------------------------
    localparam int WK_INPUT_ENABLE = 7;
    localparam int WK_PIN_A_LEVEL = 6;
    localparam int WK_PIN_B_LEVEL = 5;
    localparam int WK_A_POLARITY = 4;
    localparam int WK_B_POLARITY = 3;
    localparam int WK_A_EDGE_ENABLE = 2;
    localparam int WK_B_EDGE_ENABLE = 1;
    localparam int WK_LEVEL_AND_ENABLE = 0;

    // ------------------------------------------------------------
    // chip select map: select i owns the region whose highest set
    // address bit is SEL_BASE_BIT + i
    // ------------------------------------------------------------
    localparam int SEL_BASE_BIT = 8;
    localparam logic [7:0] INTERNAL_PAGE = 8'h00;

endpackage

// ===== logic/csw_wakeup.sv
`timescale 1ns/100ps

module csw_wakeup
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // wakeup pins from outside
    input wire logic wakeup_pin_a_in,
    input wire logic wakeup_pin_b_in,
    // configuration
    input wire logic wakeup_input_enable_in,
    input wire logic wakeup_a_polarity_in,
    input wire logic wakeup_b_polarity_in,
    input wire logic wakeup_a_edge_enable_in,
    input wire logic wakeup_b_edge_enable_in,
    input wire logic wakeup_level_and_enable_in,
    // results
    output logic level_a_out,
    output logic level_b_out,
    output logic wake_out
);

    // ------------------------------------------------------------
    // synchronisers and gated levels
    // ------------------------------------------------------------
    logic a_meta_reg, a_sync_reg, b_meta_reg, b_sync_reg;
    logic level_a_reg, level_a_next, level_b_reg, level_b_next;
    logic prev_a_reg, prev_b_reg;
    logic wake_reg, wake_next;
    logic det_a, det_b, det_prev_a, det_prev_b;

    always_comb
    begin
        // disabled inputs are held at a fixed level so a floating pin draws no current
        level_a_next = wakeup_input_enable_in ? a_sync_reg : csw_pkg::WAKE_HELD_LEVEL;
        level_b_next = wakeup_input_enable_in ? b_sync_reg : csw_pkg::WAKE_HELD_LEVEL;
        det_a = level_a_reg ^ wakeup_a_polarity_in;
        det_b = level_b_reg ^ wakeup_b_polarity_in;
        det_prev_a = prev_a_reg ^ wakeup_a_polarity_in;
        det_prev_b = prev_b_reg ^ wakeup_b_polarity_in;
        wake_next = (wakeup_a_edge_enable_in & det_a & ~det_prev_a)
                  | (wakeup_b_edge_enable_in & det_b & ~det_prev_b)
                  | (wakeup_level_and_enable_in & det_a & det_b);
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            a_meta_reg <= csw_pkg::WAKE_HELD_LEVEL;
            a_sync_reg <= csw_pkg::WAKE_HELD_LEVEL;
            b_meta_reg <= csw_pkg::WAKE_HELD_LEVEL;
            b_sync_reg <= csw_pkg::WAKE_HELD_LEVEL;
            level_a_reg <= csw_pkg::WAKE_HELD_LEVEL;
            level_b_reg <= csw_pkg::WAKE_HELD_LEVEL;
            prev_a_reg <= csw_pkg::WAKE_HELD_LEVEL;
            prev_b_reg <= csw_pkg::WAKE_HELD_LEVEL;
            wake_reg <= 1'b0;
        end
        else
        begin
            a_meta_reg <= wakeup_pin_a_in;
            a_sync_reg <= a_meta_reg;
            b_meta_reg <= wakeup_pin_b_in;
            b_sync_reg <= b_meta_reg;
            level_a_reg <= level_a_next;
            level_b_reg <= level_b_next;
            prev_a_reg <= level_a_reg;
            prev_b_reg <= level_b_reg;
            wake_reg <= wake_next;
        end
    end

    assign level_a_out = level_a_reg;
    assign level_b_out = level_b_reg;
    assign wake_out = wake_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_held_level;
        @(posedge clk_in) disable iff (!reset_n_in)
        !wakeup_input_enable_in |=> level_a_reg && level_b_reg;
    endproperty
    a_held_level: assert property (p_held_level)
        else $error("disabled wakeup input not held high");

    property p_edge_a_rise;
        @(posedge clk_in) disable iff (!reset_n_in)
        wakeup_a_edge_enable_in && !wakeup_a_polarity_in && level_a_reg && !prev_a_reg |=> wake_reg;
    endproperty
    a_edge_a_rise: assert property (p_edge_a_rise)
        else $error("rising edge on pin a gave no wakeup");

    property p_edge_b_fall;
        @(posedge clk_in) disable iff (!reset_n_in)
        wakeup_b_edge_enable_in && wakeup_b_polarity_in && !level_b_reg && prev_b_reg |=> wake_reg;
    endproperty
    a_edge_b_fall: assert property (p_edge_b_fall)
        else $error("falling edge on pin b gave no wakeup");

    property p_no_enable_no_wake;
        @(posedge clk_in) disable iff (!reset_n_in)
        !wakeup_a_edge_enable_in && !wakeup_b_edge_enable_in && !wakeup_level_and_enable_in |=> !wake_reg;
    endproperty
    a_no_enable_no_wake: assert property (p_no_enable_no_wake)
        else $error("wakeup with all sources disabled");

    property p_level_and;
        @(posedge clk_in) disable iff (!reset_n_in)
        wakeup_level_and_enable_in && (level_a_reg != wakeup_a_polarity_in)
            && (level_b_reg != wakeup_b_polarity_in) |=> wake_reg;
    endproperty
    a_level_and: assert property (p_level_and)
        else $error("level and condition gave no wakeup");

endmodule

// ===== logic/csw_chip_select_port.sv
`timescale 1ns/100ps


module csw_chip_select_port
#(
    parameter int PORT_WIDTH = 8
)
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // external address bus from the processor core
    input wire logic [15:0] addr_in,
    input wire logic addr_valid_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] wdata_in,
    input wire logic done_in,
    output logic [7:0] rdata_out,
    output logic rdata_valid_out,
    // select port pins
    input wire logic [PORT_WIDTH-1:0] port_pin_in,
    output logic [PORT_WIDTH-1:0] port_pin_out,
    output logic [PORT_WIDTH-1:0] port_pin_oe_out,
    // wakeup pins and request
    input wire logic wakeup_pin_a_in,
    input wire logic wakeup_pin_b_in,
    output logic wakeup_out
);

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] port_data_reg, port_data_next;
    logic [7:0] port_dir_reg, port_dir_next;
    logic [7:0] cs_enable_reg, cs_enable_next;
    logic [7:0] wakeup_ctrl_reg, wakeup_ctrl_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rdata_valid_reg, rdata_valid_next;
    logic [7:0] pin_meta_reg, pin_sync_reg;
    logic level_a, level_b;
    logic internal_page;
    logic [7:0] wakeup_view;

    // internal registers live only in the internal page, where no select fires
    assign internal_page = (addr_in[15:8] == csw_pkg::INTERNAL_PAGE);

    always_comb
    begin
        port_data_next = port_data_reg;
        port_dir_next = port_dir_reg;
        cs_enable_next = cs_enable_reg;
        wakeup_ctrl_next = wakeup_ctrl_reg;
        if (wr_in && internal_page)
        begin
            case (addr_in)
                csw_pkg::OFS_PORT_DATA: port_data_next = wdata_in;
                csw_pkg::OFS_PORT_DIR: port_dir_next = wdata_in;
                csw_pkg::OFS_CS_ENABLE: cs_enable_next = wdata_in;
                // the two level bits are read-only and keep their held value
                csw_pkg::OFS_WAKEUP: wakeup_ctrl_next = {wdata_in[7], wakeup_ctrl_reg[6:5], wdata_in[4:0]};
                default: port_data_next = port_data_reg;
            endcase
        end
    end

    // read view of the wakeup register: live levels replace the stored bits
    always_comb
    begin
        wakeup_view = wakeup_ctrl_reg;
        wakeup_view[csw_pkg::WK_PIN_A_LEVEL] = level_a;
        wakeup_view[csw_pkg::WK_PIN_B_LEVEL] = level_b;
    end

    always_comb
    begin
        rdata_next = rdata_reg;
        rdata_valid_next = 1'b0;
        if (rd_in)
        begin
            rdata_valid_next = 1'b1;
            rdata_next = csw_pkg::RDATA_NONE;
            if (internal_page)
            begin
                case (addr_in)
                    csw_pkg::OFS_PORT_DATA: rdata_next = pin_sync_reg;
                    csw_pkg::OFS_PORT_DIR: rdata_next = port_dir_reg;
                    csw_pkg::OFS_CS_ENABLE: rdata_next = cs_enable_reg;
                    csw_pkg::OFS_WAKEUP: rdata_next = wakeup_view;
                    default: rdata_next = csw_pkg::RDATA_NONE;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            port_data_reg <= csw_pkg::RST_PORT_DATA;
            port_dir_reg <= csw_pkg::RST_PORT_DIR;
            cs_enable_reg <= csw_pkg::RST_CS_ENABLE;
            wakeup_ctrl_reg <= csw_pkg::RST_WAKEUP;
            rdata_reg <= csw_pkg::RDATA_NONE;
            rdata_valid_reg <= 1'b0;
        end
        else
        begin
            port_data_reg <= port_data_next;
            port_dir_reg <= port_dir_next;
            cs_enable_reg <= cs_enable_next;
            wakeup_ctrl_reg <= wakeup_ctrl_next;
            rdata_reg <= rdata_next;
            rdata_valid_reg <= rdata_valid_next;
        end
    end

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    // reads see the pins two cycles late; software reads are far slower than that
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pin_meta_reg <= csw_pkg::CS_ALL_OFF;
            pin_sync_reg <= csw_pkg::CS_ALL_OFF;
        end
        else
        begin
            pin_meta_reg <= port_pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // chip select decode
    // ------------------------------------------------------------
    logic [7:0] cs_hit;
    logic [7:0] chip_select_n_reg, chip_select_n_next;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_decode
            if (gi == 7)
            begin : g_top
                assign cs_hit[gi] = addr_in[csw_pkg::SEL_BASE_BIT + gi];
            end
            else
            begin : g_mid
                assign cs_hit[gi] = addr_in[csw_pkg::SEL_BASE_BIT + gi]
                                  && (addr_in[15:csw_pkg::SEL_BASE_BIT + gi + 1] == '0);
            end
        end
    endgenerate

    always_comb
    begin
        chip_select_n_next = chip_select_n_reg;
        // a new address in the same cycle as a completion starts the next access
        if (addr_valid_in)
        begin
            chip_select_n_next = ~cs_hit;
        end
        else if (done_in)
        begin
            chip_select_n_next = csw_pkg::CS_ALL_OFF;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            chip_select_n_reg <= csw_pkg::CS_ALL_OFF;
        end
        else
        begin
            chip_select_n_reg <= chip_select_n_next;
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    logic [PORT_WIDTH-1:0] pin_out_reg, pin_out_next, pin_oe_reg, pin_oe_next;

    always_comb
    begin
        pin_out_next = (cs_enable_reg & chip_select_n_reg) | (~cs_enable_reg & port_data_reg);
        pin_oe_next = cs_enable_reg | ~port_dir_reg;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pin_out_reg <= csw_pkg::CS_ALL_OFF;
            pin_oe_reg <= csw_pkg::RST_CS_ENABLE;
        end
        else
        begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    // ------------------------------------------------------------
    // wakeup detector
    // ------------------------------------------------------------
    csw_wakeup u_wakeup
    (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .wakeup_pin_a_in(wakeup_pin_a_in),
        .wakeup_pin_b_in(wakeup_pin_b_in),
        .wakeup_input_enable_in(wakeup_ctrl_reg[csw_pkg::WK_INPUT_ENABLE]),
        .wakeup_a_polarity_in(wakeup_ctrl_reg[csw_pkg::WK_A_POLARITY]),
        .wakeup_b_polarity_in(wakeup_ctrl_reg[csw_pkg::WK_B_POLARITY]),
        .wakeup_a_edge_enable_in(wakeup_ctrl_reg[csw_pkg::WK_A_EDGE_ENABLE]),
        .wakeup_b_edge_enable_in(wakeup_ctrl_reg[csw_pkg::WK_B_EDGE_ENABLE]),
        .wakeup_level_and_enable_in(wakeup_ctrl_reg[csw_pkg::WK_LEVEL_AND_ENABLE]),
        .level_a_out(level_a),
        .level_b_out(level_b),
        .wake_out(wakeup_out)
    );

    assign rdata_out = rdata_reg;
    assign rdata_valid_out = rdata_valid_reg;
    assign port_pin_out = pin_out_reg;
    assign port_pin_oe_out = pin_oe_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_data_drive;
        @(posedge clk_in) disable iff (!reset_n_in)
        1'b1 |=> ((pin_out_reg & ~$past(cs_enable_reg)) == ($past(port_data_reg) & ~$past(cs_enable_reg)));
    endproperty
    a_data_drive: assert property (p_data_drive)
        else $error("port pin does not carry port data");

    property p_read_pins;
        @(posedge clk_in) disable iff (!reset_n_in)
        rd_in && addr_in == csw_pkg::OFS_PORT_DATA |=> rdata_valid_reg && rdata_reg == $past(pin_sync_reg);
    endproperty
    a_read_pins: assert property (p_read_pins)
        else $error("port data read does not return pin levels");

    property p_direction;
        @(posedge clk_in) disable iff (!reset_n_in)
        wr_in && addr_in == csw_pkg::OFS_PORT_DIR && cs_enable_reg == 8'h00 && !(addr_valid_in)
            |=> ##1 pin_oe_reg == ~$past(wdata_in, 2);
    endproperty
    a_direction: assert property (p_direction)
        else $error("pin enable does not follow direction");

    property p_reset_state;
        @(posedge clk_in) disable iff (!reset_n_in)
        $rose(reset_n_in) |-> pin_oe_reg == 8'hff && pin_out_reg == 8'hff && cs_enable_reg == 8'hff;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("pins are not high select outputs after reset");

    property p_select_forced;
        @(posedge clk_in) disable iff (!reset_n_in)
        1'b1 |=> ((pin_out_reg & $past(cs_enable_reg)) == ($past(chip_select_n_reg) & $past(cs_enable_reg)))
            && ((pin_oe_reg & $past(cs_enable_reg)) == $past(cs_enable_reg));
    endproperty
    a_select_forced: assert property (p_select_forced)
        else $error("enabled select pin not forced to chip select");

    property p_done_clears;
        @(posedge clk_in) disable iff (!reset_n_in)
        done_in && !addr_valid_in |=> chip_select_n_reg == 8'hff
            ##1 ((pin_out_reg & $past(cs_enable_reg)) == $past(cs_enable_reg));
    endproperty
    a_done_clears: assert property (p_done_clears)
        else $error("selects not released after access");

    property p_sel0_region;
        @(posedge clk_in) disable iff (!reset_n_in)
        addr_valid_in && addr_in[15:8] == 8'h01 |=> chip_select_n_reg == 8'hfe;
    endproperty
    a_sel0_region: assert property (p_sel0_region)
        else $error("select 0 region decoded wrongly");

    property p_sel7_region;
        @(posedge clk_in) disable iff (!reset_n_in)
        addr_valid_in && addr_in[15] |=> chip_select_n_reg == 8'h7f;
    endproperty
    a_sel7_region: assert property (p_sel7_region)
        else $error("select 7 region decoded wrongly");

    property p_internal_page;
        @(posedge clk_in) disable iff (!reset_n_in)
        addr_valid_in && addr_in[15:8] == 8'h00 |=> chip_select_n_reg == 8'hff;
    endproperty
    a_internal_page: assert property (p_internal_page)
        else $error("select asserted in internal page");

    property p_level_readback;
        @(posedge clk_in) disable iff (!reset_n_in)
        rd_in && addr_in == csw_pkg::OFS_WAKEUP |=> rdata_reg[6] == $past(level_a) && rdata_reg[5] == $past(level_b);
    endproperty
    a_level_readback: assert property (p_level_readback)
        else $error("wakeup level bits not shown on read");

    property p_wakeup_reset;
        @(posedge clk_in) disable iff (!reset_n_in)
        $rose(reset_n_in) |-> wakeup_ctrl_reg == 8'h60 && port_data_reg == 8'h00;
    endproperty
    a_wakeup_reset: assert property (p_wakeup_reset)
        else $error("register reset values wrong");

endmodule

// ===== tb/csw_periph_model.sv
`timescale 1ns/100ps

module csw_periph_model
(
    // pins of the select port and the peripheral drive
    input wire logic [7:0] pin_drive_in,
    input wire logic [7:0] pin_oe_in,
    input wire logic [7:0] ext_value_in,
    output logic [7:0] pin_level_out
);
    // ------------------------------------------------------------
    // pin resolution
    // ------------------------------------------------------------
    // a released pin shows the peripheral's value, never a stale block value
    assign pin_level_out = (pin_drive_in & pin_oe_in) | (ext_value_in & ~pin_oe_in);
endmodule

// ===== tb/chip_select_port_and_wakeup_test.sv
`timescale 1ns/100ps

module chip_select_port_and_wakeup_test;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk_in, reset_n_in, addr_valid_in, wr_in, rd_in, done_in, rdata_valid_out;
    logic wakeup_pin_a_in, wakeup_pin_b_in, wakeup_out;
    logic [15:0] addr_in, a;
    logic [7:0] wdata_in, rdata_out, port_pin_in, port_pin_out, port_pin_oe_out, ext_value, rd_val, dir, dat;
    integer failures = 0, cmp_count = 0, seed = 32'h7ee0, cycles = 0, n, i;
    logic [7:0] wk_ctrl [11] = '{8'h80, 8'h84, 8'h94, 8'h82, 8'h8a, 8'h84, 8'h99, 8'h81, 8'h91, 8'h89, 8'h81};
    logic [3:0] wk_pins [11] = '{4'h2, 4'h2, 4'h8, 4'h1, 4'h4, 4'h1, 4'h0, 4'hf, 4'h5, 4'ha, 4'ha};
    logic [7:0] wk_exp [11] = '{8'h0, 8'h1, 8'h1, 8'h1, 8'h1, 8'h0, 8'ha, 8'ha, 8'ha, 8'ha, 8'h0};

    csw_chip_select_port dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
        .addr_valid_in(addr_valid_in), .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in), .done_in(done_in),
        .rdata_out(rdata_out), .rdata_valid_out(rdata_valid_out), .port_pin_in(port_pin_in),
        .port_pin_out(port_pin_out), .port_pin_oe_out(port_pin_oe_out), .wakeup_pin_a_in(wakeup_pin_a_in),
        .wakeup_pin_b_in(wakeup_pin_b_in), .wakeup_out(wakeup_out));
    csw_periph_model periph (.pin_drive_in(port_pin_out), .pin_oe_in(port_pin_oe_out),
        .ext_value_in(ext_value), .pin_level_out(port_pin_in));

    // ------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    always @(posedge clk_in)
    begin
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            failures = failures + 1;
            $display("MISMATCH at %0t: run did not finish", $time);
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // expectations, checks and bus tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] exp_sel(input logic [15:0] adr);
        exp_sel = 8'hff;
        for (int k = 0; k < 8; k++)
            if ((adr[15:8] >> k) == 8'h01)
                exp_sel[k] = 1'b0;
    endfunction

    function automatic logic [7:0] exp_pins(input logic [7:0] d, input logic [7:0] r, input logic [7:0] e);
        exp_pins = (d & ~r) | (e & r);
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] adr, input logic [7:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= adr;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    // bounded wait: a lost valid pulse ends as a mismatch, not a hang
    task automatic rd(input logic [15:0] adr);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= adr;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        for (n = 0; n < 4 && rdata_valid_out !== 1'b1; n++)
        begin
            @(posedge clk_in);
            #1;
        end
        chk({7'h0, rdata_valid_out}, 8'h01);
        rd_val = rdata_out;
    endtask

    task automatic strobe(input logic [15:0] adr, input logic fin);
        @(posedge clk_in);
        addr_valid_in <= ~fin;
        done_in <= fin;
        addr_in <= adr;
        @(posedge clk_in);
        addr_valid_in <= 1'b0;
        done_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
    endtask

    task automatic wake_cnt(input logic [7:0] exp);
        logic [7:0] c;
        c = 8'h00;
        repeat (10)
        begin
            @(posedge clk_in);
            #1;
            c = c + {7'h0, wakeup_out};
        end
        chk(c, exp);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        reset_n_in = 1'b0;
        addr_valid_in = 1'b0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        done_in = 1'b0;
        addr_in = 16'h0000;
        wdata_in = 8'h00;
        ext_value = 8'h00;
        wakeup_pin_a_in = 1'b0;
        wakeup_pin_b_in = 1'b0;
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        chk(port_pin_oe_out, 8'hff);
        rd(csw_pkg::OFS_CS_ENABLE);
        chk(rd_val, 8'hff);
        rd(csw_pkg::OFS_WAKEUP);
        chk(rd_val, 8'h60);
        for (i = 0; i < 8; i++)
        begin
            a = (16'h0100 << i) | (16'($random(seed)) & ((16'h0100 << i) - 16'h0001));
            strobe(a, 1'b0);
            chk(port_pin_out, exp_sel(a));
            strobe(a, 1'b1);
            chk(port_pin_out, 8'hff);
        end
        strobe(16'h0042, 1'b0);
        chk(port_pin_out, 8'hff);
        $display("test chip selects done");
        wr(csw_pkg::OFS_PORT_DIR, 8'h00);
        wr(csw_pkg::OFS_PORT_DATA, 8'h5a);
        repeat (3) @(posedge clk_in);
        #1;
        chk(port_pin_out & port_pin_oe_out, 8'hff);
        wr(csw_pkg::OFS_CS_ENABLE, 8'h00);
        for (i = 0; i < 6; i++)
        begin
            dir = 8'($random(seed));
            dat = 8'($random(seed));
            ext_value <= 8'($random(seed));
            wr(csw_pkg::OFS_PORT_DIR, dir);
            wr(csw_pkg::OFS_PORT_DATA, dat);
            repeat (3) @(posedge clk_in);
            #1;
            chk(port_pin_oe_out, ~dir);
            chk(port_pin_out & ~dir, dat & ~dir);
            rd(csw_pkg::OFS_PORT_DATA);
            chk(rd_val, exp_pins(dat, dir, ext_value));
        end
        $display("test port pins done");
        for (i = 0; i < 11; i++)
        begin
            @(posedge clk_in);
            wakeup_pin_a_in <= wk_pins[i][3];
            wakeup_pin_b_in <= wk_pins[i][2];
            wr(csw_pkg::OFS_WAKEUP, wk_ctrl[i]);
            repeat (8) @(posedge clk_in);
            wakeup_pin_a_in <= wk_pins[i][1];
            wakeup_pin_b_in <= wk_pins[i][0];
            wake_cnt(wk_exp[i]);
            rd(csw_pkg::OFS_WAKEUP);
            chk(rd_val, wk_ctrl[i] | {1'b0, wk_pins[i][1:0], 5'h00});
        end
        wr(csw_pkg::OFS_WAKEUP, 8'h00);
        repeat (4) @(posedge clk_in);
        rd(csw_pkg::OFS_WAKEUP);
        chk(rd_val, 8'h60);
        $display("test wakeup done");
        finish_test();
    end
endmodule
